// ### logic/tpio_pkg.sv
// Package for the timer pin I/O mode select block.
// Shared by the channel unit and the top; offsets are byte addresses on
// a 32-bit classic Wishbone slave.
package tpio_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CH3_IO   = 8'h00;
  localparam logic [7:0] OFS_CH4_IO   = 8'h04;
  localparam logic [7:0] OFS_CH5_IO   = 8'h08;
  localparam logic [7:0] OFS_CFG      = 8'h0C;
  localparam logic [7:0] OFS_GR_CH3   = 8'h10;
  localparam logic [7:0] OFS_GR_CH4   = 8'h14;
  localparam logic [7:0] OFS_GR_CH5   = 8'h18;
  localparam logic [7:0] OFS_IRQ_STS  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MSK  = 8'h20;

  // Field positions
  localparam int IO_FLD_LSB    = 4;
  localparam int CFG_BUF_BIT   = 0;
  localparam int CFG_PSC_LSB   = 8;
  localparam int IRQ_CAP_LSB   = 3;

  // Values after reset
  localparam logic [7:0]  RST_IO      = 8'h00;
  localparam logic        RST_BUF     = 1'b0;
  localparam logic [2:0]  RST_PSC     = 3'h0;
  localparam logic [5:0]  RST_IRQ     = 6'h00;
  localparam logic [15:0] RST_GR      = 16'hFFFF;

  // Prescaler code that runs the channel 4 counter on the undivided clock
  localparam logic [2:0]  PSC_UNDIV   = 3'h0;

  typedef enum logic [7:0] {
    MODE_OUT_OFF    = 8'h01,
    MODE_OUT_LOW    = 8'h02,
    MODE_OUT_HIGH   = 8'h04,
    MODE_OUT_TOGGLE = 8'h08,
    MODE_CAP_RISE   = 8'h10,
    MODE_CAP_FALL   = 8'h20,
    MODE_CAP_BOTH   = 8'h40,
    MODE_CAP_CASC   = 8'h80
  } tpio_mode_e;

  // Upper I/O field to mode; cascade only where the channel offers it
  function automatic tpio_mode_e decode_mode(input logic [3:0] fld,
                                             input logic       casc_ok);
    tpio_mode_e m;
    m = MODE_OUT_OFF;
    if (!fld[3]) begin
      case (fld[1:0])
        2'h0:    m = MODE_OUT_OFF;
        2'h1:    m = MODE_OUT_LOW;
        2'h2:    m = MODE_OUT_HIGH;
        default: m = MODE_OUT_TOGGLE;
      endcase
    end else if (fld[2] && casc_ok) begin
      m = MODE_CAP_CASC;
    end else if (fld[1]) begin
      m = MODE_CAP_BOTH;
    end else if (fld[0]) begin
      m = MODE_CAP_FALL;
    end else begin
      m = MODE_CAP_RISE;
    end
    return m;
  endfunction : decode_mode

endpackage : tpio_pkg

// ### logic/tpio_chan_unit.sv
// One general register with its timer pin: compare output or capture.
// Assumes pin, count and tick are synchronous to i_core_clk.
`timescale 1ns/100ps
module tpio_chan_unit #(
  parameter int CW       = 16,
  parameter bit CASC_OK  = 1'b0
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_arst_n,
  // Configuration
  input  wire logic [3:0]    i_io_field,
  input  wire logic          i_inhibit,
  // Event sources
  input  wire logic          i_casc_evt,
  input  wire logic          i_pin,
  input  wire logic          i_tick,
  input  wire logic [CW-1:0] i_count,
  // Software access to the general register
  input  wire logic          i_gr_wr,
  input  wire logic [CW-1:0] i_gr_mask,
  input  wire logic [CW-1:0] i_gr_wdata,
  // Results
  output logic      [CW-1:0] o_gr,
  output logic               o_pin,
  output logic               o_pin_oe,
  output logic               o_match,
  output logic               o_capture
);
  tpio_pkg::tpio_mode_e mode;
  logic [CW-1:0] gr_ff;
  logic [3:0]    fld_prev_ff;
  logic          pin_prev_ff;
  logic          pin_ff;
  logic          match_ff;
  logic          cap_ff;
  logic          rise;
  logic          fall;
  logic          match;
  logic          cap_hit;
  logic          is_out;

  assign mode   = tpio_pkg::decode_mode(i_io_field, CASC_OK);
  assign rise   = i_pin & ~pin_prev_ff;
  assign fall   = ~i_pin & pin_prev_ff;
  assign is_out = ~i_io_field[3];
  // Buffer use suppresses both match and capture
  assign match  = ~i_inhibit & is_out & i_tick & (i_count == gr_ff); // see RL9

  always_comb begin
    case (mode)
      tpio_pkg::MODE_CAP_RISE: cap_hit = rise;        // see RL4
      tpio_pkg::MODE_CAP_FALL: cap_hit = fall;        // see RL5
      tpio_pkg::MODE_CAP_BOTH: cap_hit = rise | fall; // see RL6
      tpio_pkg::MODE_CAP_CASC: cap_hit = i_casc_evt;  // see RL7
      default:                 cap_hit = 1'b0;
    endcase
    cap_hit = cap_hit & ~i_inhibit; // see RL9
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_prev_ff <= 1'b0;
      fld_prev_ff <= 4'h0;
    end else begin
      pin_prev_ff <= i_pin;
      fld_prev_ff <= i_io_field;
    end
  end

  // Capture has priority over a software write in the same cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gr_ff <= tpio_pkg::RST_GR;
    end else if (cap_hit) begin
      gr_ff <= i_count;
    end else if (i_gr_wr) begin
      gr_ff <= (gr_ff & ~i_gr_mask) | (i_gr_wdata & i_gr_mask);
    end
  end

  // A changed field reloads the initial level from its bit two
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_ff <= 1'b0;
    end else if (i_io_field != fld_prev_ff) begin
      pin_ff <= i_io_field[2]; // see RL1
    end else if (match) begin
      case (mode)
        tpio_pkg::MODE_OUT_LOW:    pin_ff <= 1'b0;    // see RL1
        tpio_pkg::MODE_OUT_HIGH:   pin_ff <= 1'b1;    // see RL2
        tpio_pkg::MODE_OUT_TOGGLE: pin_ff <= ~pin_ff; // see RL3
        default:                   pin_ff <= pin_ff;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      match_ff <= 1'b0;
      cap_ff   <= 1'b0;
    end else begin
      match_ff <= match;
      cap_ff   <= cap_hit;
    end
  end

  assign o_gr      = gr_ff;
  assign o_pin     = pin_ff;
  assign o_pin_oe  = is_out & (mode != tpio_pkg::MODE_OUT_OFF); // see RL1
  assign o_match   = match_ff;
  assign o_capture = cap_ff;

endmodule : tpio_chan_unit

// ### logic/tpio_top.sv
// Timer pin I/O mode select for channels 3 (fourth register), 4 and 5
// (second register), with a classic Wishbone register slave.
// Assumes counters run outside; their values and step pulses come in.
//
// Notes on behaviour
// RL1: Top bit 0 makes an output compare; low bits 00 disable the pin, 01 drive it low on match, bit two picks the initial level.
// RL2: Top bit 0 with low bits 10 drives the pin high on each match from the chosen initial level.
// RL3: Top bit 0 with low bits 11 inverts the pin on each match from the chosen initial level.
// RL4: Top bit 1 with low bits 00 captures the counter on a rising pin edge.
// RL5: Top bit 1 with low bits 01 captures the counter on a falling pin edge.
// RL6: Top bit 1 with bit one set captures on both pin edges, bit zero ignored.
// RL7: Channel 3 with top bits 11 captures on every step of the channel 4 counter, low bits ignored.
// RL8: That channel 4 step source gives no capture while channel 4 runs on the undivided clock.
// RL9: With channel 3 buffer mode set, its register neither matches nor captures.
// RL10: Channel 4 with top bits 11 captures whenever channel 3's third register matches or captures.
// RL11: Channel 5 ignores bit two in capture mode and has no cascaded source.
`timescale 1ns/100ps
module tpio_top #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_arst_n,
  // Wishbone classic slave
  input  wire logic          i_wb_cyc,
  input  wire logic          i_wb_stb,
  input  wire logic          i_wb_we,
  input  wire logic [7:0]    i_wb_adr,
  input  wire logic [3:0]    i_wb_sel,
  input  wire logic [31:0]   i_wb_dat,
  output logic      [31:0]   o_wb_dat,
  output logic               o_wb_ack,
  // Counter values and step pulses from the timer channels
  input  wire logic [CW-1:0] i_ch3_counter,
  input  wire logic          i_ch3_tick,
  input  wire logic [CW-1:0] i_ch4_counter,
  input  wire logic          i_ch4_tick,
  input  wire logic [CW-1:0] i_ch5_counter,
  input  wire logic          i_ch5_tick,
  // Match or capture of channel 3's third general register
  input  wire logic          i_ch3_reg_three_evt,
  // Timer pins
  input  wire logic          i_ch3_pin_four,
  output logic               o_ch3_pin_four,
  output logic               o_ch3_pin_four_oe,
  input  wire logic          i_ch4_pin_two,
  output logic               o_ch4_pin_two,
  output logic               o_ch4_pin_two_oe,
  input  wire logic          i_ch5_pin_two,
  output logic               o_ch5_pin_two,
  output logic               o_ch5_pin_two_oe,
  // Event pulses and interrupt
  output logic      [2:0]    o_match,
  output logic      [2:0]    o_capture,
  output logic               o_irq
);
  localparam int NCH = 3;

  // Bus request decode
  logic            req;
  logic            wr;
  logic            ack_ff;
  logic [31:0]     rdat_ff;
  logic [31:0]     wmask;
  logic [31:0]     rd_mux;

  // Control state
  logic [7:0]      io_ff [NCH];
  logic            buffer_mode_reg_two_ff;
  logic [2:0]      prescale_sel_ff;
  logic [5:0]      irq_sts_ff;
  logic [5:0]      irq_msk_ff;

  // Per-channel wiring
  logic [CW-1:0]   cnt   [NCH];
  logic [NCH-1:0]  tick;
  logic [NCH-1:0]  pin_in;
  logic [NCH-1:0]  pin_out;
  logic [NCH-1:0]  pin_oe;
  logic [NCH-1:0]  casc;
  logic [NCH-1:0]  inhibit;
  logic [NCH-1:0]  gr_wr;
  logic [NCH-1:0]  match;
  logic [NCH-1:0]  capture;
  logic [CW-1:0]   gr    [NCH];
  logic [5:0]      irq_evt;
  logic            ch4_step_ok;

  localparam logic [7:0] IO_OFS [NCH] = '{tpio_pkg::OFS_CH3_IO,
                                          tpio_pkg::OFS_CH4_IO,
                                          tpio_pkg::OFS_CH5_IO};
  localparam logic [7:0] GR_OFS [NCH] = '{tpio_pkg::OFS_GR_CH3,
                                          tpio_pkg::OFS_GR_CH4,
                                          tpio_pkg::OFS_GR_CH5};

  // Word address compare, byte lanes ignored in the address
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  // One-cycle answer: request seen, ack raised at the next edge
  assign req = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign wr  = req & i_wb_we;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{i_wb_sel[b]}};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Channel wiring into arrays
  assign cnt[0]  = i_ch3_counter;
  assign cnt[1]  = i_ch4_counter;
  assign cnt[2]  = i_ch5_counter;
  assign tick    = {i_ch5_tick, i_ch4_tick, i_ch3_tick};
  assign pin_in  = {i_ch5_pin_two, i_ch4_pin_two, i_ch3_pin_four};

  // Channel 4 steps are no capture source on the undivided clock
  assign ch4_step_ok = prescale_sel_ff != tpio_pkg::PSC_UNDIV; // see RL8
  assign casc[0] = i_ch4_tick & ch4_step_ok;                   // see RL7
  assign casc[1] = i_ch3_reg_three_evt;                        // see RL10
  assign casc[2] = 1'b0;                                       // see RL11

  assign inhibit = {1'b0, 1'b0, buffer_mode_reg_two_ff};       // see RL9

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      // Upper field steers the unit, lower nibble only stored
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          io_ff[c] <= tpio_pkg::RST_IO;
        end else if (wr && hit(i_wb_adr, IO_OFS[c]) && i_wb_sel[0]) begin
          io_ff[c] <= i_wb_dat[7:0];
        end
      end

      assign gr_wr[c] = wr & hit(i_wb_adr, GR_OFS[c]);

      tpio_chan_unit #(
        .CW      (CW),
        .CASC_OK (c != 2)
      ) u_unit (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_io_field (io_ff[c][tpio_pkg::IO_FLD_LSB +: 4]),
        .i_inhibit  (inhibit[c]),
        .i_casc_evt (casc[c]),
        .i_pin      (pin_in[c]),
        .i_tick     (tick[c]),
        .i_count    (cnt[c]),
        .i_gr_wr    (gr_wr[c]),
        .i_gr_mask  (wmask[CW-1:0]),
        .i_gr_wdata (i_wb_dat[CW-1:0]),
        .o_gr       (gr[c]),
        .o_pin      (pin_out[c]),
        .o_pin_oe   (pin_oe[c]),
        .o_match    (match[c]),
        .o_capture  (capture[c])
      );
    end
  endgenerate

  // Mode configuration
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buffer_mode_reg_two_ff <= tpio_pkg::RST_BUF;
      prescale_sel_ff        <= tpio_pkg::RST_PSC;
    end else if (wr && hit(i_wb_adr, tpio_pkg::OFS_CFG)) begin
      if (i_wb_sel[0]) begin
        buffer_mode_reg_two_ff <= i_wb_dat[tpio_pkg::CFG_BUF_BIT];
      end
      if (i_wb_sel[1]) begin
        prescale_sel_ff <= i_wb_dat[tpio_pkg::CFG_PSC_LSB +: 3];
      end
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  assign irq_evt = {capture, match};

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_sts_ff <= tpio_pkg::RST_IRQ;
    end else if (wr && hit(i_wb_adr, tpio_pkg::OFS_IRQ_STS)
                 && i_wb_sel[0]) begin
      irq_sts_ff <= (irq_sts_ff & ~i_wb_dat[5:0]) | irq_evt;
    end else begin
      irq_sts_ff <= irq_sts_ff | irq_evt;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_msk_ff <= tpio_pkg::RST_IRQ;
    end else if (wr && hit(i_wb_adr, tpio_pkg::OFS_IRQ_MSK)
                 && i_wb_sel[0]) begin
      irq_msk_ff <= i_wb_dat[5:0];
    end
  end

  // Read mux; unmapped words answer with zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(i_wb_adr, tpio_pkg::OFS_CH3_IO)) begin
      rd_mux[7:0] = io_ff[0];
    end else if (hit(i_wb_adr, tpio_pkg::OFS_CH4_IO)) begin
      rd_mux[7:0] = io_ff[1];
    end else if (hit(i_wb_adr, tpio_pkg::OFS_CH5_IO)) begin
      rd_mux[7:0] = io_ff[2];
    end else if (hit(i_wb_adr, tpio_pkg::OFS_CFG)) begin
      rd_mux[tpio_pkg::CFG_BUF_BIT]      = buffer_mode_reg_two_ff;
      rd_mux[tpio_pkg::CFG_PSC_LSB +: 3] = prescale_sel_ff;
    end else if (hit(i_wb_adr, tpio_pkg::OFS_GR_CH3)) begin
      rd_mux[CW-1:0] = gr[0];
    end else if (hit(i_wb_adr, tpio_pkg::OFS_GR_CH4)) begin
      rd_mux[CW-1:0] = gr[1];
    end else if (hit(i_wb_adr, tpio_pkg::OFS_GR_CH5)) begin
      rd_mux[CW-1:0] = gr[2];
    end else if (hit(i_wb_adr, tpio_pkg::OFS_IRQ_STS)) begin
      rd_mux[5:0] = irq_sts_ff;
    end else if (hit(i_wb_adr, tpio_pkg::OFS_IRQ_MSK)) begin
      rd_mux[5:0] = irq_msk_ff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req && !i_wb_we) begin
      rdat_ff <= rd_mux;
    end
  end

  // Outputs
  assign o_wb_ack          = ack_ff;
  assign o_wb_dat          = rdat_ff;
  assign o_ch3_pin_four    = pin_out[0];
  assign o_ch3_pin_four_oe = pin_oe[0];
  assign o_ch4_pin_two     = pin_out[1];
  assign o_ch4_pin_two_oe  = pin_oe[1];
  assign o_ch5_pin_two     = pin_out[2];
  assign o_ch5_pin_two_oe  = pin_oe[2];
  assign o_match           = match;
  assign o_capture         = capture;
  assign o_irq             = |(irq_sts_ff & irq_msk_ff);

endmodule : tpio_top

// ### verif/tpio_pin_model.sv
// External pin model: resolves each timer pin from both drivers.
// Far side drives the commanded level only while the block is off.
`timescale 1ns/100ps
module tpio_pin_model (
  // Block side
  input  wire logic [2:0] i_dut_lvl,
  input  wire logic [2:0] i_dut_oe,
  // Far side command
  input  wire logic [2:0] i_drv,
  // Resolved pin levels
  output logic      [2:0] o_wire
);
  assign o_wire = (i_dut_oe & i_dut_lvl) | (~i_dut_oe & i_drv);
endmodule : tpio_pin_model

// ### verif/tpio_assertions.sv
// Timing checks for the timer pin block, on top ports only.
// Bound to the top from the bench; one clock domain.
`timescale 1ns/100ps
module tpio_assertions (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  // Watched ports
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic        i_ch4_tick,
  input wire logic        i_ch5_tick,
  input wire logic        i_ch3_reg_three_evt,
  input wire logic        i_ch3_pin_four,
  input wire logic        i_ch4_pin_two,
  input wire logic        i_ch5_pin_two,
  input wire logic        o_ch5_pin_two,
  input wire logic [2:0]  o_match,
  input wire logic [2:0]  o_capture
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  // Pin level differs between the two previous samples
  sequence s_pin_edge(p);
    $past(p) != $past(p, 2);
  endsequence

  a_ack_follows: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_rdat_upper: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_match4_tick: assert property (o_match[1] |-> $past(i_ch4_tick))
    else $error("ch4 match without tick");
  a_match5_tick: assert property (o_match[2] |-> $past(i_ch5_tick))
    else $error("ch5 match without tick");
  a_cap5_edge: assert property (
    o_capture[2] |-> s_pin_edge(i_ch5_pin_two))
    else $error("ch5 capture without pin edge");
  a_cap3_source: assert property (
    o_capture[0] |-> s_pin_edge(i_ch3_pin_four) or $past(i_ch4_tick))
    else $error("ch3 capture without source");
  a_cap4_source: assert property (
    o_capture[1] |-> s_pin_edge(i_ch4_pin_two) or $past(i_ch3_reg_three_evt))
    else $error("ch4 capture without source");
  a_pin5_moves: assert property (
    $changed(o_ch5_pin_two) |->
      o_match[2] || o_wb_ack || $past(o_wb_ack) || $past(o_wb_ack, 2))
    else $error("ch5 pin moved without cause");
endmodule : tpio_assertions

// ### verif/timer_pin_io_mode_select_bench.sv
// Self-checking bench for the timer pin I/O mode select block.
// Assumes the package, top, pin model and checker are compiled first.
`timescale 1ns/100ps
module timer_pin_io_mode_select_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic        ev3 = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  logic [15:0] cnt3 = 16'h0;
  logic [15:0] cnt4 = 16'h0;
  logic [15:0] cnt5 = 16'h0;
  logic [2:0]  tk = 3'h0;
  logic [2:0]  drv = 3'h0;
  logic [2:0]  pin_w, pin_o, pin_oe, mt, cp;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc_n = 0;

  always #4 clk = ~clk;

  tpio_top dut_u (
    .i_core_clk(clk), .i_arst_n(rst_n),
    .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ch3_counter(cnt3), .i_ch3_tick(tk[0]),
    .i_ch4_counter(cnt4), .i_ch4_tick(tk[1]),
    .i_ch5_counter(cnt5), .i_ch5_tick(tk[2]),
    .i_ch3_reg_three_evt(ev3),
    .i_ch3_pin_four(pin_w[0]), .o_ch3_pin_four(pin_o[0]),
    .o_ch3_pin_four_oe(pin_oe[0]),
    .i_ch4_pin_two(pin_w[1]), .o_ch4_pin_two(pin_o[1]),
    .o_ch4_pin_two_oe(pin_oe[1]),
    .i_ch5_pin_two(pin_w[2]), .o_ch5_pin_two(pin_o[2]),
    .o_ch5_pin_two_oe(pin_oe[2]),
    .o_match(mt), .o_capture(cp), .o_irq(irq));

  tpio_pin_model pm_u (.i_dut_lvl(pin_o), .i_dut_oe(pin_oe),
                       .i_drv(drv), .o_wire(pin_w));

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // Classic cycle; ack and data are read as sampled at the edge, and the
  // request is released at that same edge
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      err_total++;
      $display("unexpected ack expected 1 seen %b", ack);
    end
    rd = rdat;
    req <= 1'b0;
  endtask : wb

  task automatic rchk(logic [7:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk

  task automatic t_regs();
    rchk(tpio_pkg::OFS_CH3_IO, 32'h0);
    rchk(tpio_pkg::OFS_CH5_IO, 32'h0);
    rchk(tpio_pkg::OFS_GR_CH3, 32'hFFFF);
    rchk(tpio_pkg::OFS_IRQ_MSK, 32'h0);
    wb(1'b1, 8'h40, 32'hFF);
    rchk(8'h40, 32'h0);
  endtask : t_regs

  task automatic t_cmp();
    logic [3:0] f;
    logic       ex;
    wb(1'b1, tpio_pkg::OFS_GR_CH5, 32'h1234);
    for (int i = 7; i >= 0; i--) begin
      f = i[3:0];
      wb(1'b1, tpio_pkg::OFS_CH5_IO, {24'h0, f, 4'h0});
      settle();
      chk("oe5", {31'h0, f[1:0] != 2'h0}, {31'h0, pin_oe[2]});
      if (f[1:0] != 2'h0) begin
        chk("init5", {31'h0, f[2]}, {31'h0, pin_o[2]});
      end
      @(posedge clk);
      cnt5 <= 16'h1234;
      tk[2] <= 1'b1;
      @(posedge clk);
      tk[2] <= 1'b0;
      #1;
      ex = (f[1:0] == 2'h1) ? 1'b0 : (f[1:0] == 2'h2) ? 1'b1 : !f[2];
      chk("match5", 32'h1, {31'h0, mt[2]});
      if (f[1:0] != 2'h0) begin
        chk("pin5", {31'h0, ex}, {31'h0, pin_o[2]});
      end
    end
  endtask : t_cmp

  task automatic t_cap();
    logic [3:0] f [4] = '{4'h8, 4'h9, 4'hA, 4'hE};
    logic [1:0] e [4] = '{2'b01, 2'b10, 2'b11, 2'b11};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, tpio_pkg::OFS_CH5_IO, {24'h0, f[i], 4'h0});
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        drv[2] <= (j == 0);
        cnt5 <= 16'h0A00 + 16'(2 * i + j);
        settle();
        chk("cap5", {31'h0, e[i][j]}, {31'h0, cp[2]});
      end
    end
    rchk(tpio_pkg::OFS_GR_CH5, 32'h0A07);
  endtask : t_cap

  task automatic t_irq();
    rchk(tpio_pkg::OFS_IRQ_STS, 32'h24);
    wb(1'b1, tpio_pkg::OFS_IRQ_MSK, 32'h20);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, tpio_pkg::OFS_IRQ_MSK, 32'h01);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, tpio_pkg::OFS_IRQ_STS, 32'h04);
    rchk(tpio_pkg::OFS_IRQ_STS, 32'h20);
  endtask : t_irq

  task automatic pulse4(logic [15:0] v);
    @(posedge clk);
    tk[1] <= 1'b1;
    cnt3 <= v;
    cnt4 <= v;
    @(posedge clk);
    tk[1] <= 1'b0;
    #1;
  endtask : pulse4

  task automatic t_casc();
    wb(1'b1, tpio_pkg::OFS_CH3_IO, 32'hC0);
    wb(1'b1, tpio_pkg::OFS_CH4_IO, 32'hF5);
    pulse4(16'h0055);
    chk("cap3", 32'h0, {31'h0, cp[0]});
    wb(1'b1, tpio_pkg::OFS_CFG, 32'h100);
    pulse4(16'h0056);
    chk("cap3", 32'h1, {31'h0, cp[0]});
    rchk(tpio_pkg::OFS_GR_CH3, 32'h0056);
    wb(1'b1, tpio_pkg::OFS_CFG, 32'h101);
    pulse4(16'h0057);
    chk("cap3", 32'h0, {31'h0, cp[0]});
    @(posedge clk);
    ev3 <= 1'b1;
    cnt4 <= 16'h0077;
    @(posedge clk);
    ev3 <= 1'b0;
    #1;
    chk("cap4", 32'h1, {31'h0, cp[1]});
    rchk(tpio_pkg::OFS_GR_CH4, 32'h0077);
  endtask : t_casc

  // Toggle compare on ch3 and ch4; ch3 silent while buffer mode is set
  task automatic t_cmp34();
    wb(1'b1, tpio_pkg::OFS_GR_CH3, 32'h0100);
    wb(1'b1, tpio_pkg::OFS_GR_CH4, 32'h0100);
    wb(1'b1, tpio_pkg::OFS_CH3_IO, 32'h30);
    wb(1'b1, tpio_pkg::OFS_CH4_IO, 32'h70);
    settle();
    chk("oe3", 32'h1, {31'h0, pin_oe[0]});
    chk("init3", 32'h0, {31'h0, pin_o[0]});
    chk("oe4", 32'h1, {31'h0, pin_oe[1]});
    chk("init4", 32'h1, {31'h0, pin_o[1]});
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      tk[1:0] <= 2'h3;
      cnt3 <= 16'h0100;
      cnt4 <= 16'h0100;
      @(posedge clk);
      tk[1:0] <= 2'h0;
      #1;
      chk("match3", 32'(k), {31'h0, mt[0]});
      chk("pin3", 32'(k), {31'h0, pin_o[0]});
      chk("match4", 32'h1, {31'h0, mt[1]});
      chk("pin4", 32'(k), {31'h0, pin_o[1]});
      if (k == 0) begin
        wb(1'b1, tpio_pkg::OFS_CFG, 32'h100);
      end
    end
  endtask : t_cmp34

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_cmp();
    t_cap();
    t_irq();
    t_casc();
    t_cmp34();
    final_report();
  end
endmodule : timer_pin_io_mode_select_bench

bind tpio_top tpio_assertions chk_u (
  .i_core_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_wb_dat,
  .i_ch4_tick, .i_ch5_tick, .i_ch3_reg_three_evt, .i_ch3_pin_four,
  .i_ch4_pin_two, .i_ch5_pin_two, .o_ch5_pin_two, .o_match, .o_capture);
